// file: verilog/boe_pkg.sv
// Constants for the bit-oriented instruction execution block
package boe_pkg;
  localparam int IW_WIDTH  = 14;
  localparam int ADDR_W    = 7;
  localparam int BITSEL_W  = 3;
  localparam int DATA_W    = 8;
  localparam int ADDR_LSB  = 0;
  localparam int BSEL_LSB  = 7;
  localparam int OPC_LSB   = 10;
  localparam int OPC_W     = 4;
  localparam logic [3:0] OPC_CLR   = 4'h4;
  localparam logic [3:0] OPC_SET   = 4'h5;
  localparam logic [3:0] OPC_TSTZ  = 4'h6;
  localparam logic [3:0] OPC_TSTO  = 4'h7;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  typedef enum logic [1:0] {
    BOE_NONE, BOE_CLR, BOE_SET, BOE_TEST
  } boe_op_t;
endpackage : boe_pkg

// file: verilog/boe_bit_unit.sv
// Combinational bit modify and test unit
`timescale 1ns/10ps
`default_nettype none
module boe_bit_unit (
  input  wire logic [7:0] data_i,
  input  wire logic [2:0] bsel_i,
  input  wire logic       set_i,
  output logic      [7:0] data_o,
  output logic            bit_o
);
  wire [7:0] mask_w = 8'h01 << bsel_i;
  // Other bits pass unchanged
  assign data_o = set_i ? (data_i | mask_w) : (data_i & ~mask_w);
  assign bit_o  = |(data_i & mask_w);
endmodule : boe_bit_unit
`default_nettype wire

// file: verilog/boe_exec.sv
// Bit-oriented instruction decode and execute stage
// Contract
// - Clear or set selected file bit only
// - Test bit, skip next when zero
// - Test bit, skip next when one
// - Taken skip discards prefetch, runs no-op
// - Single word; set one cycle; test 1(2)
// - Address low seven bits, selector next three
`timescale 1ns/10ps
`default_nettype none
module boe_exec (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_en_i,
  input  wire logic [13:0] instr_i,
  input  wire logic [7:0]  rd_data_i,
  output logic      [6:0]  rd_addr_o,
  output logic      [6:0]  wr_addr_o,
  output logic      [7:0]  wr_data_o,
  output logic             wr_en_o,
  output logic             flush_o,
  output logic             skip_nop_o,
  output logic             flags_we_o,
  output logic             busy_o
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The fixed port widths above only serve this field layout
  if (boe_pkg::ADDR_LSB + boe_pkg::ADDR_W != boe_pkg::BSEL_LSB) begin : g_bad_addr
    $error("address field does not meet the selector field");
  end
  if (boe_pkg::BSEL_LSB + boe_pkg::BITSEL_W != boe_pkg::OPC_LSB) begin : g_bad_bsel
    $error("selector field does not meet the opcode field");
  end
  if (boe_pkg::OPC_LSB + boe_pkg::OPC_W != boe_pkg::IW_WIDTH) begin : g_bad_opc
    $error("opcode field does not end at the word top");
  end
  if ((1 << boe_pkg::BITSEL_W) != boe_pkg::DATA_W) begin : g_bad_data
    $error("selector cannot reach every data bit");
  end
  if (boe_pkg::ADDR_W != 7) begin : g_bad_port
    $error("address ports are seven bits wide");
  end
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire [3:0] opc_w = instr_i[boe_pkg::OPC_LSB +: boe_pkg::OPC_W];
  wire [6:0] addr_w = instr_i[boe_pkg::ADDR_LSB +: boe_pkg::ADDR_W];
  wire [2:0] bsel_w = instr_i[boe_pkg::BSEL_LSB +: boe_pkg::BITSEL_W];
  // A word replaced by a no-op must not execute, so decode is gated
  wire       live_w = cyc_en_i && !skip_nop_o;
  wire       is_clr_w = live_w && (opc_w == boe_pkg::OPC_CLR);
  wire       is_set_w = live_w && (opc_w == boe_pkg::OPC_SET);
  wire       is_tz_w = live_w && (opc_w == boe_pkg::OPC_TSTZ);
  wire       is_to_w = live_w && (opc_w == boe_pkg::OPC_TSTO);
  wire [7:0] mod_w;
  wire       bit_w;
  boe_bit_unit u_bit (
    .data_i (rd_data_i),
    .bsel_i (bsel_w),
    .set_i  (is_set_w),
    .data_o (mod_w),
    .bit_o  (bit_w)
  );
  wire skip_w = (is_tz_w && !bit_w) || (is_to_w && bit_w);
  // Read address follows instruction so the bit unit sees current data
  always_comb rd_addr_o = addr_w;
  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_addr_o  <= 7'h00;
      wr_data_o  <= 8'h00;
      wr_en_o    <= 1'b0;
      flush_o    <= 1'b0;
      skip_nop_o <= 1'b0;
      flags_we_o <= 1'b0;
      busy_o     <= 1'b0;
    end else if (cyc_en_i) begin
      wr_en_o    <= is_clr_w || is_set_w;
      wr_addr_o  <= addr_w;
      wr_data_o  <= mod_w;
      flush_o    <= skip_w;
      skip_nop_o <= skip_w;
      busy_o     <= skip_w;
      flags_we_o <= 1'b0;
    end else begin
      wr_en_o <= 1'b0;
      flush_o <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Skip sequencing: a taken skip is the test cycle plus one no-op
  skip_one_cyc_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cyc_en_i && skip_w |=> skip_nop_o && flush_o) else $error("skip lost");
  nop_no_write_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cyc_en_i && skip_nop_o |=> !wr_en_o) else $error("no-op wrote");
  nop_no_skip_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cyc_en_i && skip_nop_o |=> !skip_nop_o && !flush_o)
    else $error("no-op skipped");
  flush_pulse_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    flush_o |=> !flush_o) else $error("flush held");
  skip_hold_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    skip_nop_o && !cyc_en_i |=> skip_nop_o) else $error("skip dropped");
  busy_copy_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    busy_o == skip_nop_o) else $error("busy differs from skip");
  // ---------------------------------------------------------------
  // Bit tests
  // ---------------------------------------------------------------
  tz_skip_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_tz_w && !rd_data_i[bsel_w] |=> skip_nop_o) else $error("tz skip");
  tz_stay_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_tz_w && rd_data_i[bsel_w] |=> !skip_nop_o) else $error("tz no skip");
  to_skip_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_to_w && rd_data_i[bsel_w] |=> skip_nop_o) else $error("to skip");
  to_stay_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_to_w && !rd_data_i[bsel_w] |=> !skip_nop_o) else $error("to no skip");
  test_no_write_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (is_tz_w || is_to_w) |=> !wr_en_o) else $error("test wrote");
  other_no_skip_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cyc_en_i && !(is_tz_w || is_to_w) |=> !skip_nop_o)
    else $error("skip without test");
  // ---------------------------------------------------------------
  // Bit writes
  // ---------------------------------------------------------------
  clr_write_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_clr_w |=> wr_en_o && !wr_data_o[$past(bsel_w)]) else $error("clr bad");
  clr_keep_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_clr_w |=>
      (wr_data_o | (8'h01 << $past(bsel_w))) ==
      ($past(rd_data_i) | (8'h01 << $past(bsel_w))))
    else $error("clr touched other bits");
  set_write_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_set_w |=> wr_en_o && wr_data_o[$past(bsel_w)]) else $error("set bad");
  set_keep_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_set_w |=>
      (wr_data_o & ~(8'h01 << $past(bsel_w))) ==
      ($past(rd_data_i) & ~(8'h01 << $past(bsel_w))))
    else $error("set touched other bits");
  other_no_write_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    cyc_en_i && !(is_clr_w || is_set_w) |=> !wr_en_o)
    else $error("write without bit op");
  idle_no_write_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !cyc_en_i |=> !wr_en_o) else $error("write between cycles");
  addr_pass_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_set_w |=> wr_addr_o == $past(instr_i[6:0])) else $error("addr");
  clr_addr_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    is_clr_w |=> wr_addr_o == $past(instr_i[6:0])) else $error("clr addr");
  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // No bit operation may touch carry, digit carry or zero
  flags_kept_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !flags_we_o) else $error("flags touched");
endmodule : boe_exec
`default_nettype wire

// file: dv/boe_exec_bench.sv
// Self-checking bench for the bit-oriented execution stage
`timescale 1ns/10ps
`default_nettype none
module boe_exec_bench;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        cyc_en_i   = 1'b0;
  logic [13:0] instr_i    = 14'h0000;
  logic [7:0]  rd_data_i  = 8'h00;
  logic [6:0]  rd_addr_o, wr_addr_o;
  logic [7:0]  wr_data_o;
  logic        wr_en_o, flush_o, skip_nop_o, flags_we_o, busy_o;
  int          mismatches = 0;
  int          checks     = 0;
  // Row: word, file data, expected write data, write, skip
  logic [31:0] rows [6] = '{{14'h13ff, 8'hc7, 8'h47, 2'b10},
    {14'h1407, 8'h0a, 8'h0b, 2'b10}, {14'h1885, 8'h00, 8'h00, 2'b01},
    {14'h1885, 8'h02, 8'h00, 2'b00}, {14'h1f80, 8'h80, 8'h00, 2'b01},
    {14'h1f80, 8'h7f, 8'h00, 2'b00}};
  boe_exec u_boe_exec (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cyc_en_i(cyc_en_i), .instr_i(instr_i), .rd_data_i(rd_data_i),
    .rd_addr_o(rd_addr_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .wr_en_o(wr_en_o), .flush_o(flush_o), .skip_nop_o(skip_nop_o),
    .flags_we_o(flags_we_o), .busy_o(busy_o));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic final_report();
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial forever #2.5 core_clk_i = ~core_clk_i;
  initial begin
    #2000;
    mismatches++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Table walk; each word is followed back to back by a bit set
  // ----------------------------------------------------------------
  initial begin
    logic [13:0] ins;
    logic [7:0]  rd, dt;
    logic        we, sk;
    repeat (5) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    foreach (rows[i]) begin
      {ins, rd, dt, we, sk} = rows[i];
      cyc_en_i = 1'b1; instr_i = ins; rd_data_i = rd;
      #1 chk("rd_addr", {1'b0, rd_addr_o}, {1'b0, ins[6:0]});
      @(posedge core_clk_i); #1;
      chk("wr_en", {7'h00, wr_en_o}, {7'h00, we});
      if (we) chk("wr_addr", {1'b0, wr_addr_o}, {1'b0, ins[6:0]});
      if (we) chk("wr_data", wr_data_o, dt);
      chk("skip", {5'h00, flush_o, skip_nop_o, busy_o}, {5'h00, {3{sk}}});
      chk("flags", {7'h00, flags_we_o}, 8'h00);
      instr_i = 14'h1407; rd_data_i = 8'h00;
      @(posedge core_clk_i); #1;
      chk("next_wr", {7'h00, wr_en_o}, {7'h00, ~sk});
      chk("next_skip", {6'h00, flush_o, skip_nop_o}, 8'h00);
      cyc_en_i = 1'b0;
      @(posedge core_clk_i); #1;
      chk("pulse", {7'h00, wr_en_o}, 8'h00);
    end
    // Skip held over an idle gap; the discarded word is itself a test
    cyc_en_i = 1'b1; instr_i = 14'h1885; rd_data_i = 8'h00;
    @(posedge core_clk_i); #1;
    cyc_en_i = 1'b0;
    chk("gap_skip", {6'h00, flush_o, skip_nop_o}, 8'h03);
    @(posedge core_clk_i); #1;
    chk("gap_hold", {5'h00, flush_o, skip_nop_o, busy_o}, 8'h03);
    cyc_en_i = 1'b1;
    @(posedge core_clk_i); #1;
    chk("refused", {5'h00, wr_en_o, flush_o, skip_nop_o}, 8'h00);
    instr_i = 14'h13ff; rd_data_i = 8'hc7;
    @(posedge core_clk_i); #1;
    chk("resume_wr", {wr_en_o, wr_addr_o}, 8'hff);
    chk("resume_data", wr_data_o, 8'h47);
    // Reset in mid-skip drops the pending no-op
    instr_i = 14'h1885; rd_data_i = 8'h00;
    @(posedge core_clk_i); #1;
    rst_i = 1'b1;
    @(posedge core_clk_i); #1;
    chk("mid_reset", {6'h00, skip_nop_o, busy_o}, 8'h00);
    rst_i = 1'b0; instr_i = 14'h1407;
    @(posedge core_clk_i); #1;
    chk("after_reset", {wr_en_o, wr_addr_o}, 8'h87);
    // A skipping test held under reset must leave write enable, flush, skip and busy low
    rst_i = 1'b1; cyc_en_i = 1'b1; instr_i = 14'h1885;
    @(posedge core_clk_i); #1;
    chk("reset", {4'h0, wr_en_o, flush_o, skip_nop_o, busy_o}, 8'h00);
    final_report();
  end
endmodule : boe_exec_bench
`default_nettype wire
